// ---- inc/osc_ctrl_regs.svh ----
// Register offsets, field positions, reset values and timing counts of the oscillator control block.
`ifndef OSC_CTRL_REGS_SVH
`define OSC_CTRL_REGS_SVH
`define IDX_INT_FLAGS 10'h00C
`define IDX_INT_ENABLES 10'h08C
`define IDX_OSC_CONTROL 10'h08F
`define IDX_OSC_TRIM 10'h090
`define ADDR_OF(idx) ({idx, 2'b00})
`define OSC_FAIL_BIT 2
`define IFS_LSB 4
`define IFS_MSB 6
`define EXT_ACTIVE_BIT 3
`define HF_STABLE_BIT 2
`define LF_STABLE_BIT 1
`define SRC_SEL_BIT 0
`define IFS_RESET 3'h6
`define TRIM_RESET 5'h00
`define INT_FLAGS_RESET 8'h00
`define INT_ENABLES_RESET 8'h00
`define OST_CYCLES 11'h400
`define SAMPLE_DIVIDE 7'h40
`endif

// ---- inc/osc_ctrl_pkg.sv ----
// Types shared by the oscillator control block.
package osc_ctrl_pkg;
    typedef enum logic [3:0] {
        ST_SLEEP = 4'b0001,
        ST_STARTUP = 4'b0010,
        ST_EXTERNAL = 4'b0100,
        ST_FAILSAFE = 4'b1000
    } clk_state_t;

    typedef enum logic [2:0] {
        low_power_crystal_mode = 3'h0,
        crystal_mode = 3'h1,
        high_speed_crystal_mode = 3'h2,
        ext_clock_input_mode = 3'h3,
        resistor_capacitor_mode = 3'h4
    } osc_mode_t;
endpackage

// ---- rtl/oscillator_control_failsafe_startup.sv ----
// Oscillator control with start-up timer, fail-safe clock monitor and APB register slave.
//
// Notes on behaviour
// - In external clock or RC mode, monitoring starts right after reset or sleep.
// - Failure detection only after reset/sleep exit and, in crystal modes, start-up timer expiry.
// - Crystal modes run on internal oscillator until the start-up timer expires.
// - Once external oscillator is stable, low internal oscillator feeds monitor sample clock.
// - Frequency select codes 000..111 pick 31k,125k,250k,500k,1M,2M,4M,8M.
// - Reset loads frequency select 110, clears stability flags and source select.
// - Trim clears on power-on or brown-out reset only, kept otherwise.
// - On failure set fail flag, interrupt if enabled, switch to internal oscillator.
// - Monitor sample clock is low internal oscillator divided by 64.
// - Start-up timer counts 1024 external cycles before external clock counts as stable.
// - Fail-safe ends on reset, sleep, or write that changes source select.
`timescale 1ns/1ps
`include "osc_ctrl_regs.svh"

module oscillator_control_failsafe_startup (
    // Clock and resets
    input wire logic pclk,
    input wire logic presetn,
    input wire logic por_resetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Configuration and oscillator status
    input wire logic [2:0] osc_mode,
    input wire logic fail_monitor_enable,
    input wire logic ext_osc_tick,
    input wire logic lfint_tick,
    input wire logic hf_osc_ready,
    input wire logic lf_osc_ready,
    // Power management events
    input wire logic sleep_enter,
    input wire logic wake_event,
    // Clock steering and interrupt
    output logic use_internal_clock,
    output logic [2:0] internal_freq_select,
    output logic [4:0] freq_trim,
    output logic sample_from_lfint,
    output logic monitor_active,
    output logic irq
);
    osc_ctrl_pkg::clk_state_t state;
    osc_ctrl_pkg::clk_state_t next_state;
    osc_ctrl_pkg::clk_state_t resume_state;
    logic clock_source_select;
    logic high_freq_osc_stable;
    logic low_freq_osc_stable;
    logic [7:0] int_flags;
    logic [7:0] int_enables;
    logic [9:0] ost_count;
    logic [5:0] sample_div;
    logic edge_seen;
    logic reset_done;

    function automatic logic needs_startup(input logic [2:0] mode);
        needs_startup = (mode == osc_ctrl_pkg::low_power_crystal_mode) ||
                        (mode == osc_ctrl_pkg::crystal_mode) ||
                        (mode == osc_ctrl_pkg::high_speed_crystal_mode);
    endfunction

    // Each register takes one aligned word, so a hit is an exact byte-address match.
    function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] byte_addr);
        reg_hit = (addr == byte_addr);
    endfunction

    // Bus decode.
    wire setup_phase = psel && !penable;
    wire access_phase = psel && penable;
    wire hit_flags = reg_hit(paddr, `ADDR_OF(`IDX_INT_FLAGS));
    wire hit_enables = reg_hit(paddr, `ADDR_OF(`IDX_INT_ENABLES));
    wire hit_control = reg_hit(paddr, `ADDR_OF(`IDX_OSC_CONTROL));
    wire hit_trim = reg_hit(paddr, `ADDR_OF(`IDX_OSC_TRIM));
    wire hit_any = hit_flags || hit_enables || hit_control || hit_trim;
    wire wr_access = access_phase && pwrite;
    wire rd_access = access_phase && !pwrite;
    wire wr_control = wr_access && hit_control;
    wire wr_flags = wr_access && hit_flags;
    wire wr_enables = wr_access && hit_enables;
    wire wr_trim = wr_access && hit_trim;

    // The registers are plain flops, so every access completes without wait states.
    assign pready = 1'b1;
    // An unmapped address answers with an error and its write is dropped.
    assign pslverr = access_phase && !hit_any;

    // State decodes shared by the steering, monitor, timer and flag logic.
    wire in_startup = (state == osc_ctrl_pkg::ST_STARTUP);
    wire in_external = (state == osc_ctrl_pkg::ST_EXTERNAL);
    wire in_failsafe = (state == osc_ctrl_pkg::ST_FAILSAFE);

    // Clock state derived from the running source.
    wire ext_active = in_external && !clock_source_select;
    wire [7:0] control_view = {1'b0, internal_freq_select, ext_active,
                               high_freq_osc_stable, low_freq_osc_stable, clock_source_select};

    wire [7:0] read_mux = hit_flags ? int_flags :
                          hit_enables ? int_enables :
                          hit_control ? control_view :
                          hit_trim ? {3'h0, freq_trim} : 8'h00;

    // Start-up timer and monitor sampling.
    wire ost_done = in_startup && ext_osc_tick &&
                    (ost_count == 10'(`OST_CYCLES - 11'h001));
    wire sample_end = lfint_tick && (sample_div == 6'(`SAMPLE_DIVIDE - 7'h01));
    // A window that closes with no external tick in it, nor on its last edge, means the clock has died.
    wire window_empty = !edge_seen && !ext_osc_tick;
    wire clock_failed = monitor_active && sample_end && window_empty;
    wire src_changed = wr_control && (pwdata[`SRC_SEL_BIT] != clock_source_select);

    assign resume_state = needs_startup(osc_mode) ? osc_ctrl_pkg::ST_STARTUP
                                                  : osc_ctrl_pkg::ST_EXTERNAL;

    // Only external running is monitored; start-up and fail-safe are not.
    assign monitor_active = fail_monitor_enable && in_external;
    assign sample_from_lfint = in_external;
    assign use_internal_clock = clock_source_select || !in_external;
    assign irq = |(int_flags & int_enables);

    // Sleep parks the machine, and start-up runs on the internal clock while the timer counts.
    // External is the only monitored state, and fail-safe waits for sleep or a source change.
    always_comb
    begin
        next_state = state;
        case (state)
            osc_ctrl_pkg::ST_SLEEP:
            begin
                if (wake_event)
                    next_state = resume_state;
            end
            osc_ctrl_pkg::ST_STARTUP:
            begin
                if (sleep_enter)
                    next_state = osc_ctrl_pkg::ST_SLEEP;
                else if (ost_done)
                    next_state = osc_ctrl_pkg::ST_EXTERNAL;
            end
            osc_ctrl_pkg::ST_EXTERNAL:
            begin
                if (sleep_enter)
                    next_state = osc_ctrl_pkg::ST_SLEEP;
                else if (clock_failed)
                    next_state = osc_ctrl_pkg::ST_FAILSAFE;
            end
            osc_ctrl_pkg::ST_FAILSAFE:
            begin
                if (sleep_enter)
                    next_state = osc_ctrl_pkg::ST_SLEEP;
                else if (src_changed)
                    next_state = resume_state;
            end
            default:
            begin
                next_state = resume_state;
            end
        endcase
    end

    // The reset branch may only load a constant, so reset parks the machine in sleep.
    // On the first edge after release the mode decides between start-up and running.
    // A reset thus clears fail-safe and restarts the timer just like a wake from sleep.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state <= osc_ctrl_pkg::ST_SLEEP;
        else if (state == osc_ctrl_pkg::ST_SLEEP && !reset_done)
            state <= resume_state;
        else
            state <= next_state;
    end

    // Marks that the first cycle after reset release has passed.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            reset_done <= 1'b0;
        else
            reset_done <= 1'b1;
    end

    // The timer restarts whenever start-up is entered, so a sleep aborts a partial count.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ost_count <= 10'h000;
        else if (!in_startup)
            ost_count <= 10'h000;
        else if (ext_osc_tick)
            ost_count <= ost_count + 10'h001;
    end

    // Divider and edge latch are held cleared outside monitoring so the first window is full.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sample_div <= 6'h00;
        else if (!monitor_active)
            sample_div <= 6'h00;
        else if (lfint_tick)
            sample_div <= sample_div + 6'h01;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            edge_seen <= 1'b0;
        else if (!monitor_active || sample_end)
            edge_seen <= 1'b0;
        else if (ext_osc_tick)
            edge_seen <= 1'b1;
    end

    // Oscillator control fields.
    // Frequency select writes are honoured in fail-safe too, so software can retune there.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            internal_freq_select <= `IFS_RESET;
        else if (wr_control)
            internal_freq_select <= pwdata[`IFS_MSB:`IFS_LSB];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            clock_source_select <= 1'b0;
        else if (wr_control)
            clock_source_select <= pwdata[`SRC_SEL_BIT];
    end

    // Stability flags trail their oscillator ready inputs by one cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            high_freq_osc_stable <= 1'b0;
        else
            high_freq_osc_stable <= hf_osc_ready;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            low_freq_osc_stable <= 1'b0;
        else
            low_freq_osc_stable <= lf_osc_ready;
    end

    // Trim survives ordinary resets; only power-on or brown-out clears it.
    always_ff @(posedge pclk or negedge por_resetn)
    begin
        if (!por_resetn)
            freq_trim <= `TRIM_RESET;
        else if (wr_trim)
            freq_trim <= pwdata[4:0];
    end

    // Enable bit 2 gates the fail flag onto the interrupt line.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            int_enables <= `INT_ENABLES_RESET;
        else if (wr_enables)
            int_enables <= pwdata[7:0];
    end

    // Fail flag: read clears it, but not while fail-safe persists, and a new failure wins.
    wire rd_flags = rd_access && hit_flags;
    wire fail_clear = rd_flags && !in_failsafe;
    wire [7:0] next_flags_sw = wr_flags ? pwdata[7:0] : int_flags;

    genvar b;
    generate
        for (b = 0; b < 8; b = b + 1)
        begin : g_flag
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    int_flags[b] <= 1'(`INT_FLAGS_RESET >> b);
                else if (b == `OSC_FAIL_BIT)
                    int_flags[b] <= clock_failed || (int_flags[b] && !fail_clear);
                else
                    int_flags[b] <= next_flags_sw[b];
            end
        end
    endgenerate

    // Read data is captured in the setup cycle so it leaves a flip-flop.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (setup_phase && !pwrite)
            prdata <= {24'h000000, read_mux};
    end
endmodule

// ---- verif/osc_ctrl_properties.sv ----
// Concurrent checks on the ports of the oscillator control block.
`timescale 1ns/1ps
module osc_ctrl_properties (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pslverr,
    // Configuration and outputs
    input wire logic [2:0] osc_mode,
    input wire logic fail_monitor_enable,
    input wire logic use_internal_clock,
    input wire logic [2:0] internal_freq_select,
    input wire logic [4:0] freq_trim,
    input wire logic monitor_active,
    input wire logic irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire wr = psel && penable && pwrite;
    wire mapped = paddr inside {12'h030, 12'h230, 12'h23C, 12'h240};
    a_ifs_reset: assert property ($rose(presetn) |-> internal_freq_select == 3'h6)
        else $error("frequency select not 6 after reset");
    a_ifs_write: assert property (wr && paddr == 12'h23C |=> internal_freq_select == $past(pwdata[6:4]))
        else $error("frequency select not written");
    a_trim_write: assert property (wr && paddr == 12'h240 |=> freq_trim == $past(pwdata[4:0]))
        else $error("trim not written");
    a_src_internal: assert property (wr && paddr == 12'h23C && pwdata[0] |=> use_internal_clock)
        else $error("source select 1 not internal");
    a_ext_monitor: assert property ($rose(presetn) && fail_monitor_enable && osc_mode inside {3'h3, 3'h4}
        |=> monitor_active)
        else $error("monitor not armed at once");
    a_xtal_internal: assert property ($rose(presetn) && osc_mode < 3'h3 |=> use_internal_clock [*8])
        else $error("crystal start not on internal clock");
    a_xtal_nomon: assert property ($rose(presetn) && osc_mode < 3'h3 |=> !monitor_active [*8])
        else $error("monitor armed during start-up");
    a_fail_switch: assert property ($rose(irq) && !$past(wr) |-> use_internal_clock)
        else $error("failure without internal clock");
    a_unmapped_err: assert property (psel && penable |-> pslverr == !mapped)
        else $error("slave error wrong");
endmodule

bind oscillator_control_failsafe_startup osc_ctrl_properties osc_ctrl_properties_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pslverr(pslverr), .osc_mode(osc_mode), .fail_monitor_enable(fail_monitor_enable),
    .use_internal_clock(use_internal_clock), .internal_freq_select(internal_freq_select),
    .freq_trim(freq_trim), .monitor_active(monitor_active), .irq(irq));

// ---- verif/oscillator_control_failsafe_startup_tb.sv ----
// Register-level testbench of the oscillator control block.
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module oscillator_control_failsafe_startup_tb;
    localparam logic [11:0] A_FLAG = 12'h030, A_EN = 12'h230, A_CTRL = 12'h23C, A_TRIM = 12'h240;
    logic pclk = 0, presetn = 0, por_resetn = 0, psel = 0, penable = 0, pwrite = 0, s;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, ext_osc_tick = 0, lfint_tick = 0, ext_run = 1, sleep_enter = 0, wake_event = 0;
    logic [2:0] osc_mode = 3'h3, internal_freq_select;
    logic use_internal_clock, sample_from_lfint, monitor_active, irq;
    logic hf_ready = 1, lf_ready = 1;
    logic [4:0] freq_trim;
    int errors = 0, num_checks = 0, n, ticks;
    oscillator_control_failsafe_startup oscillator_control_failsafe_startup_i (.pclk(pclk), .presetn(presetn),
        .por_resetn(por_resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_mode(osc_mode),
        .fail_monitor_enable(1'b1), .ext_osc_tick(ext_osc_tick), .lfint_tick(lfint_tick),
        .hf_osc_ready(hf_ready), .lf_osc_ready(lf_ready), .sleep_enter(sleep_enter), .wake_event(wake_event),
        .use_internal_clock(use_internal_clock), .internal_freq_select(internal_freq_select),
        .freq_trim(freq_trim), .sample_from_lfint(sample_from_lfint), .monitor_active(monitor_active),
        .irq(irq));
    initial forever #5 pclk = ~pclk;
    // Both oscillators tick every other cycle, so a monitor window is 128 cycles.
    always @(posedge pclk)
    begin
        ext_osc_tick <= ext_run && !ext_osc_tick;
        lfint_tick <= !lfint_tick;
        ticks <= !presetn ? 0 : ticks + int'(ext_osc_tick);
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        s = pslverr;
        psel <= 0;
        penable <= 0;
        if (n >= 20)
        begin
            errors++;
            end_sim();
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(q, {24'h0, e})
    endtask
    task automatic rst();
        @(posedge pclk);
        presetn <= 0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1;
        por_resetn <= 1;
        repeat (2) @(posedge pclk);
        rd(A_CTRL, 8'h6E);
        rd(A_TRIM, 8'h00);
        rd(A_FLAG, 8'h00);
        rd(A_EN, 8'h00);
        apb(1'b0, 12'h100, 32'h0);
        `CHK({s, q}, {1'b1, 32'h0})
        for (int c = 0; c < 8; c++)
        begin
            apb(1'b1, A_CTRL, {24'h0, 1'b1, c[2:0], 4'hE});
            rd(A_CTRL, {1'b0, c[2:0], 4'hE});
            `CHK(internal_freq_select, c[2:0])
        end
        hf_ready <= 0;
        rd(A_CTRL, 8'h7A);
        hf_ready <= 1;
        lf_ready <= 0;
        rd(A_CTRL, 8'h7C);
        lf_ready <= 1;
        $display("test registers done");
        apb(1'b1, A_TRIM, 32'h1F);
        rst();
        rd(A_TRIM, 8'h1F);
        rd(A_CTRL, 8'h6E);
        @(posedge pclk);
        por_resetn <= 0;
        @(posedge pclk);
        por_resetn <= 1;
        rd(A_TRIM, 8'h00);
        apb(1'b1, A_CTRL, 32'h61);
        #1 `CHK(use_internal_clock, 1'b1)
        rd(A_CTRL, 8'h67);
        apb(1'b1, A_CTRL, 32'h60);
        #1 `CHK(use_internal_clock, 1'b0)
        $display("test resets and source done");
        apb(1'b1, A_EN, 32'h04);
        ext_run <= 0;
        n = 0;
        while (irq !== 1'b1 && n < 400)
        begin
            @(posedge pclk);
            #1;
            n++;
        end
        `CHK(n >= 125 && n <= 262, 1'b1)
        if (n >= 400)
            end_sim();
        `CHK(use_internal_clock, 1'b1)
        rd(A_CTRL, 8'h66);
        rd(A_FLAG, 8'h04);
        rd(A_FLAG, 8'h04);
        apb(1'b1, A_EN, 32'h00);
        #1 `CHK(irq, 1'b0)
        apb(1'b1, A_EN, 32'h04);
        #1 `CHK(irq, 1'b1)
        ext_run <= 1;
        apb(1'b1, A_CTRL, 32'h61);
        apb(1'b1, A_CTRL, 32'h60);
        rd(A_FLAG, 8'h04);
        rd(A_FLAG, 8'h00);
        #1 `CHK({irq, use_internal_clock}, 2'b00)
        $display("test failure done");
        osc_mode <= 3'h1;
        rst();
        n = 0;
        while (use_internal_clock !== 1'b0 && n < 3000)
        begin
            @(posedge pclk);
            #1;
            n++;
        end
        `CHK(ticks >= 1024 && ticks <= 1026, 1'b1)
        if (n >= 3000)
            end_sim();
        `CHK(sample_from_lfint, 1'b1)
        rd(A_CTRL, 8'h6E);
        @(posedge pclk);
        sleep_enter <= 1;
        @(posedge pclk);
        sleep_enter <= 0;
        wake_event <= 1;
        @(posedge pclk);
        wake_event <= 0;
        #1 `CHK({monitor_active, use_internal_clock}, 2'b01)
        n = 0;
        while (use_internal_clock !== 1'b0 && n < 3000)
        begin
            @(posedge pclk);
            #1;
            n++;
        end
        `CHK(n >= 2040 && n <= 2056, 1'b1)
        if (n >= 3000)
            end_sim();
        $display("test start-up done");
        end_sim();
    end
endmodule
